// [design/fp_nan_result.sv]
// Operand classes and untrapped special-value results of the FP unit
`timescale 1ns/1ps
module fp_nan_result
  import fp_nan_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic op_valid,
  input wire op_e op_kind,
  input wire logic op_dbl,
  input wire logic [63:0] first_source_operand,
  input wire logic [63:0] second_source_operand,
  input wire logic [63:0] arith_result,
  input wire logic arith_invalid,
  output logic result_valid,
  output logic [63:0] result,
  output logic result_dbl,
  output logic invalid_exc,
  output logic unimpl_trap,
  output logic unfinished_exc,
  output class_e first_class,
  output class_e second_class,
  output logic signed [11:0] first_true_exp
);
  fp_class_if cls_if[2] ();

  logic [63:0] src_ops [2];
  class_e kind_w [2];
  logic sign_w [2];
  logic [10:0] exp_w [2];
  logic [51:0] frac_w [2];
  logic src_dbl;

  logic result_valid_q, result_valid_d;
  logic [63:0] result_q, result_d;
  logic result_dbl_q, result_dbl_d;
  logic invalid_q, invalid_d;
  logic unimpl_q, unimpl_d;
  class_e first_class_q, first_class_d;
  class_e second_class_q, second_class_d;
  logic signed [11:0] true_exp_q, true_exp_d;

  logic first_qnan, second_qnan, first_signaling_nan, second_signaling_nan;
  logic second_nan;
  logic [63:0] default_nan;

  // Source precision follows the conversion, not the destination
  function automatic logic source_is_dbl(input op_e k, input logic dbl);
    logic r;
    r = dbl;
    case (k)
      OP_STOI, OP_STOD: r = 1'b0;
      OP_DTOI, OP_DTOS: r = 1'b1;
      default: r = dbl;
    endcase
    return r;
  endfunction

  // Quiet NaN out with its sign bit forced clear
  function automatic logic [63:0] quiet_out(input logic [63:0] v,
                                            input logic dbl);
    logic [63:0] r;
    r = v;
    if (dbl) begin
      r[DP_SIGN_POS] = 1'b0;
    end else begin
      r = {32'h0, v[31:0]};
      r[SP_SIGN_POS] = 1'b0;
    end
    return r;
  endfunction

  function automatic logic [63:0] nan_pattern(input logic dbl);
    return dbl ? DEFAULT_NAN_DP : {32'h0, DEFAULT_NAN_SP};
  endfunction

  assign src_ops[0] = first_source_operand;
  assign src_ops[1] = second_source_operand;
  assign src_dbl = source_is_dbl(op_kind, op_dbl);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_cls
      fp_operand_classify u_classify (
        .operand(src_ops[g]),
        .dbl(src_dbl),
        .cls(cls_if[g].producer)
      );
      assign kind_w[g] = cls_if[g].kind;
      assign sign_w[g] = cls_if[g].sign;
      assign exp_w[g] = cls_if[g].exp;
      assign frac_w[g] = cls_if[g].frac;
    end
  endgenerate

  assign first_qnan = (kind_w[0] == CLS_QNAN);
  assign second_qnan = (kind_w[1] == CLS_QNAN);
  assign first_signaling_nan = (kind_w[0] == CLS_SIGNALING_NAN);
  assign second_signaling_nan = (kind_w[1] == CLS_SIGNALING_NAN);
  assign second_nan = second_qnan | second_signaling_nan;
  assign default_nan = nan_pattern(op_dbl);

  always_comb begin
    result_valid_d = op_valid;
    result_d = result_q;
    result_dbl_d = result_dbl_q;
    invalid_d = 1'b0;
    unimpl_d = 1'b0;
    first_class_d = first_class_q;
    second_class_d = second_class_q;
    true_exp_d = true_exp_q;
    if (op_valid) begin
      first_class_d = kind_w[0];
      second_class_d = kind_w[1];
      true_exp_d = 12'sh000;
      if (kind_w[0] == CLS_NORMAL) begin
        true_exp_d = $signed({1'b0, exp_w[0]})
                   - $signed({1'b0, src_dbl ? DP_BIAS : SP_BIAS});
      end
      // Datapath result is already rounded to half an LSB
      result_d = arith_result;
      result_dbl_d = op_dbl;
      case (op_kind)
        OP_ARITH: begin
          if (first_signaling_nan || second_signaling_nan) begin
            result_d = default_nan;
            invalid_d = 1'b1;
          end else if (first_qnan) begin
            result_d = quiet_out(first_source_operand, op_dbl);
          end else if (second_qnan) begin
            result_d = quiet_out(second_source_operand, op_dbl);
          end else if (arith_invalid) begin
            result_d = default_nan;
            invalid_d = 1'b1;
          end
        end
        OP_STOI, OP_DTOI: begin
          result_dbl_d = 1'b0;
          if (second_nan) begin
            // NaN cannot be represented in an integer
            result_d = {32'h0, sign_w[1] ? INT_NEG_SAT : INT_POS_SAT};
            invalid_d = 1'b1;
          end else if (arith_invalid) begin
            invalid_d = 1'b1;
          end
        end
        OP_STOD: begin
          result_dbl_d = 1'b1;
          if (second_qnan) begin
            result_d = {1'b0, DP_EXP_MAX, frac_w[1][SP_FRAC_W-1:0],
                        29'h0};
          end else if (second_signaling_nan) begin
            result_d = DEFAULT_NAN_DP;
            invalid_d = 1'b1;
          end
        end
        OP_DTOS: begin
          result_dbl_d = 1'b0;
          if (second_nan) begin
            result_d = {32'h0, DEFAULT_NAN_SP};
            invalid_d = second_signaling_nan;
          end else if (arith_invalid) begin
            result_d = {32'h0, DEFAULT_NAN_SP};
            invalid_d = 1'b1;
          end
        end
        default: begin
          // Extended precision goes to software emulation
          result_d = 64'h0;
          unimpl_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      result_valid_q <= 1'b0;
      result_q <= 64'h0;
      result_dbl_q <= 1'b0;
      invalid_q <= 1'b0;
      unimpl_q <= 1'b0;
      first_class_q <= CLS_ZERO;
      second_class_q <= CLS_ZERO;
      true_exp_q <= 12'sh000;
    end else begin
      result_valid_q <= result_valid_d;
      result_q <= result_d;
      result_dbl_q <= result_dbl_d;
      invalid_q <= invalid_d;
      unimpl_q <= unimpl_d;
      first_class_q <= first_class_d;
      second_class_q <= second_class_d;
      true_exp_q <= true_exp_d;
    end
  end

  assign result_valid = result_valid_q;
  assign result = result_q;
  assign result_dbl = result_dbl_q;
  assign invalid_exc = invalid_q;
  assign unimpl_trap = unimpl_q;
  assign unfinished_exc = 1'b0;
  assign first_class = first_class_q;
  assign second_class = second_class_q;
  assign first_true_exp = true_exp_q;

  sequence s_req(op_e k);
    op_valid && op_kind == k;
  endsequence

  sequence s_arith_signaling_nan;
    s_req(OP_ARITH) ##0 (first_signaling_nan || second_signaling_nan);
  endsequence

  sequence s_arith_first_q;
    s_req(OP_ARITH) ##0 (!first_signaling_nan && !second_signaling_nan && first_qnan);
  endsequence

  chk_never_unfinished: assert property (
    @(posedge clock) disable iff (srst)
    op_valid && kind_w[0] == CLS_DENORMAL |=> !unfinished_exc && result_valid)
    else $error("denormal operand raised unfinished");

  chk_ext_trap: assert property (
    @(posedge clock) disable iff (srst)
    s_req(OP_EXT) |=> unimpl_trap && result_valid
    ##1 (!unimpl_trap || $past(op_valid) && $past(op_kind) == OP_EXT))
    else $error("extended op did not trap for one cycle");

  chk_signaling_nan_invalid: assert property (
    @(posedge clock) disable iff (srst)
    op_valid && second_signaling_nan && op_kind != OP_EXT |=> invalid_exc)
    else $error("signaling NaN without invalid");

  chk_qnan_no_exc: assert property (
    @(posedge clock) disable iff (srst)
    s_req(OP_ARITH) ##0 (first_qnan && !second_signaling_nan && !arith_invalid)
    |=> !invalid_exc)
    else $error("quiet NaN raised invalid");

  chk_default_nan: assert property (
    @(posedge clock) disable iff (srst)
    s_arith_signaling_nan |=> result == $past(default_nan))
    else $error("signaling NaN did not give default NaN");

  chk_first_priority: assert property (
    @(posedge clock) disable iff (srst)
    s_arith_first_q |=> result[30:0] == $past(first_source_operand[30:0]))
    else $error("first source quiet NaN not chosen");

  chk_qnan_sign: assert property (
    @(posedge clock) disable iff (srst)
    s_arith_first_q |=> (result_dbl ? !result[63] : !result[31]))
    else $error("quiet NaN result kept its sign");

  chk_nan_sat: assert property (
    @(posedge clock) disable iff (srst)
    (s_req(OP_STOI) or s_req(OP_DTOI)) ##0 (second_nan && sign_w[1])
    |=> result[31:0] == INT_NEG_SAT && !result_dbl)
    else $error("negative NaN not saturated");

  chk_stod_copy: assert property (
    @(posedge clock) disable iff (srst)
    s_req(OP_STOD) ##0 second_qnan
    |=> result[51:29] == $past(second_source_operand[22:0])
        && result[28:0] == 29'h0 && !result[63])
    else $error("single to double NaN copy wrong");

  chk_dtos_default: assert property (
    @(posedge clock) disable iff (srst)
    s_req(OP_DTOS) ##0 second_nan |=> result == {32'h0, DEFAULT_NAN_SP})
    else $error("double to single NaN not default");

  chk_invalid_quiet: assert property (
    @(posedge clock) disable iff (srst)
    s_req(OP_ARITH) ##0 (arith_invalid && !first_qnan && !second_qnan)
    |=> invalid_exc && result == $past(default_nan))
    else $error("untrapped invalid not a quiet NaN");

  chk_zero_class: assert property (
    @(posedge clock) disable iff (srst)
    op_valid && op_kind == OP_ARITH && !op_dbl
    && first_source_operand[30:0] == 31'h0 |=> first_class == CLS_ZERO)
    else $error("zero operand misclassified");

  chk_norm_exp: assert property (
    @(posedge clock) disable iff (srst)
    op_valid && op_kind == OP_ARITH && !op_dbl
    && first_source_operand[30:23] == 8'h7F |=> first_true_exp == 12'sh000)
    else $error("single bias not applied");

  chk_inf_class: assert property (
    @(posedge clock) disable iff (srst)
    op_valid && op_kind == OP_ARITH && op_dbl
    && first_source_operand[62:0] == {DP_EXP_MAX, 52'h0}
    |=> first_class == CLS_INF)
    else $error("double infinity misclassified");
endmodule // fp_nan_result

// [design/fp_nan_pkg.sv]
// Constants and types for operand classification and NaN result selection
package fp_nan_pkg;
  localparam int SP_SIGN_POS = 31;
  localparam int SP_EXP_LSB = 23;
  localparam int SP_EXP_W = 8;
  localparam int SP_FRAC_W = 23;
  localparam int DP_SIGN_POS = 63;
  localparam int DP_EXP_LSB = 52;
  localparam int DP_EXP_W = 11;
  localparam int DP_FRAC_W = 52;
  localparam logic [7:0] SP_EXP_MAX = 8'hFF;
  localparam logic [10:0] DP_EXP_MAX = 11'h7FF;
  localparam logic [10:0] SP_BIAS = 11'h07F;
  localparam logic [10:0] DP_BIAS = 11'h3FF;
  localparam logic [31:0] DEFAULT_NAN_SP = 32'h7FFF0000;
  localparam logic [63:0] DEFAULT_NAN_DP = 64'h7FFFE00000000000;
  localparam logic [31:0] INT_POS_SAT = 32'h7FFFFFFF;
  localparam logic [31:0] INT_NEG_SAT = 32'h80000000;

  typedef enum logic [2:0] {
    CLS_ZERO, CLS_DENORMAL, CLS_NORMAL, CLS_INF, CLS_QNAN, CLS_SIGNALING_NAN
  } class_e;

  typedef enum logic [2:0] {
    OP_ARITH, OP_STOI, OP_DTOI, OP_STOD, OP_DTOS, OP_EXT
  } op_e;
endpackage

// [design/fp_class_if.sv]
// Classification of one operand, from classifier to result logic
`timescale 1ns/1ps
interface fp_class_if;
  import fp_nan_pkg::*;
  class_e kind;
  logic sign;
  logic [10:0] exp;
  logic [51:0] frac;
  modport producer (output kind, output sign, output exp, output frac);
  modport consumer (input kind, input sign, input exp, input frac);
endinterface

// [design/fp_operand_classify.sv]
// Field split and class decode of one single or double operand
`timescale 1ns/1ps
module fp_operand_classify
  import fp_nan_pkg::*;
(
  input wire logic [63:0] operand,
  input wire logic dbl,
  fp_class_if.producer cls
);
  logic [10:0] exp_v;
  logic [51:0] frac_v;
  logic sign_v;
  logic exp_ones;
  logic frac_msb;

  always_comb begin
    if (dbl) begin
      sign_v = operand[DP_SIGN_POS];
      exp_v = operand[DP_EXP_LSB +: DP_EXP_W];
      frac_v = operand[DP_FRAC_W-1:0];
      exp_ones = (exp_v == DP_EXP_MAX);
      frac_msb = frac_v[DP_FRAC_W-1];
    end else begin
      sign_v = operand[SP_SIGN_POS];
      exp_v = {3'h0, operand[SP_EXP_LSB +: SP_EXP_W]};
      frac_v = {29'h0, operand[SP_FRAC_W-1:0]};
      exp_ones = (exp_v == {3'h0, SP_EXP_MAX});
      frac_msb = frac_v[SP_FRAC_W-1];
    end
  end

  always_comb begin
    if (exp_v == 11'h000) begin
      // Signed zero kept apart from denormal
      cls.kind = (frac_v == 52'h0) ? CLS_ZERO : CLS_DENORMAL;
    end else if (exp_ones) begin
      if (frac_v == 52'h0) begin
        cls.kind = CLS_INF;
      end else begin
        cls.kind = frac_msb ? CLS_QNAN : CLS_SIGNALING_NAN;
      end
    end else begin
      cls.kind = CLS_NORMAL;
    end
  end

  assign cls.sign = sign_v;
  assign cls.exp = exp_v;
  assign cls.frac = frac_v;
endmodule // fp_operand_classify

// [tb/fp_issue_model.sv]
// Integer-unit model that issues one floating-point operation at a time
`timescale 1ns/1ps
module fp_issue_model
  import fp_nan_pkg::*;
(
  input wire logic clock,
  output logic op_valid,
  output op_e op_kind,
  output logic op_dbl,
  output logic [63:0] first_source_operand,
  output logic [63:0] second_source_operand,
  output logic [63:0] arith_result,
  output logic arith_invalid
);
  initial begin
    op_valid = 1'b0;
    op_kind = OP_ARITH;
    op_dbl = 1'b0;
    first_source_operand = 64'h0;
    second_source_operand = 64'h0;
    arith_result = 64'h0;
    arith_invalid = 1'b0;
  end

  // Raise or replace a request; back to back calls give one per cycle
  task automatic drive(input op_e k, input logic d, input logic [63:0] a,
                       input logic [63:0] b, input logic inv);
    @(negedge clock);
    op_valid = 1'b1;
    op_kind = k;
    op_dbl = d;
    first_source_operand = a;
    second_source_operand = b;
    arith_result = 64'h0000000040490FDB;
    arith_invalid = inv;
  endtask

  // Operands are inverted once taken, so stale values never look valid
  task automatic release_bus;
    @(negedge clock);
    op_valid = 1'b0;
    op_dbl = ~op_dbl;
    first_source_operand = ~first_source_operand;
    second_source_operand = ~second_source_operand;
    arith_result = ~arith_result;
    arith_invalid = ~arith_invalid;
  endtask

  task automatic issue(input op_e k, input logic d, input logic [63:0] a,
                       input logic [63:0] b, input logic inv);
    drive(k, d, a, b, inv);
    release_bus();
  endtask
endmodule // fp_issue_model

// [tb/fp_nan_result_tb.sv]
// Self-checking bench for operand classes and NaN result selection
`timescale 1ns/1ps
module fp_nan_result_tb;
  import fp_nan_pkg::*;
  localparam logic [63:0] AR = 64'h0000000040490FDB;
  localparam logic [63:0] DS = {32'h0, DEFAULT_NAN_SP};
  localparam logic [63:0] CV [16] = '{64'h0, 64'h80000000, 64'h1,
    64'h00800000, 64'h7F7FFFFF, 64'h7F800000, 64'hFFC00000, 64'h7F800001,
    64'h7FBFFFFF, 64'h8000000000000000, 64'h000FFFFFFFFFFFFF,
    64'h0010000000000000, 64'h7FEFFFFFFFFFFFFF, 64'hFFF0000000000000,
    64'h7FF8000000000000, 64'h7FF0000000000001};
  localparam class_e CC [16] = '{CLS_ZERO, CLS_ZERO, CLS_DENORMAL,
    CLS_NORMAL, CLS_NORMAL, CLS_INF, CLS_QNAN, CLS_SIGNALING_NAN, CLS_SIGNALING_NAN,
    CLS_ZERO, CLS_DENORMAL, CLS_NORMAL, CLS_NORMAL, CLS_INF, CLS_QNAN,
    CLS_SIGNALING_NAN};
  localparam int CE [16] = '{0, 0, 0, -126, 127, 0, 0, 0, 0, 0, 0, -1022,
    1023, 0, 0, 0};
  logic clock;
  logic srst;
  logic op_valid;
  op_e op_kind;
  logic op_dbl;
  logic [63:0] first_source_operand;
  logic [63:0] second_source_operand;
  logic [63:0] arith_result;
  logic arith_invalid;
  logic result_valid;
  logic [63:0] result;
  logic result_dbl;
  logic invalid_exc;
  logic unimpl_trap;
  logic unfinished_exc;
  class_e first_class;
  class_e second_class;
  logic signed [11:0] first_true_exp;
  int failures = 0;
  int n_checks = 0;

  fp_issue_model i_fp_issue_model (.clock(clock), .op_valid(op_valid),
    .op_kind(op_kind), .op_dbl(op_dbl),
    .first_source_operand(first_source_operand),
    .second_source_operand(second_source_operand),
    .arith_result(arith_result), .arith_invalid(arith_invalid));

  fp_nan_result i_fp_nan_result (.clock(clock), .srst(srst),
    .op_valid(op_valid), .op_kind(op_kind), .op_dbl(op_dbl),
    .first_source_operand(first_source_operand),
    .second_source_operand(second_source_operand),
    .arith_result(arith_result), .arith_invalid(arith_invalid),
    .result_valid(result_valid), .result(result), .result_dbl(result_dbl),
    .invalid_exc(invalid_exc), .unimpl_trap(unimpl_trap),
    .unfinished_exc(unfinished_exc), .first_class(first_class),
    .second_class(second_class), .first_true_exp(first_true_exp));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Reset mid-run too, so held outputs must really clear
  task automatic t_reset;
    @(negedge clock);
    srst = 1'b1;
    repeat (12) @(negedge clock);
    srst = 1'b0;
    chk("rst result", result, 64'h0);
    chk("rst class", 64'(first_class), 64'(CLS_ZERO));
    chk("rst valid", 64'(result_valid), 64'h0);
    chk("rst dbl", 64'(result_dbl), 64'h0);
  endtask

  task automatic do_op(op_e k, logic d, logic [63:0] a, logic [63:0] b,
                       logic inv, logic [63:0] er, logic ei);
    int i;
    i_fp_issue_model.issue(k, d, a, b, inv);
    for (i = 0; i < 3 && result_valid !== 1'b1; i++) @(negedge clock);
    if (result_valid !== 1'b1) begin
      failures++;
      end_sim();
    end
    chk("latency", 64'(i), 64'h0);
    chk("result", result, er);
    chk("invalid", 64'(invalid_exc), 64'(ei));
    chk("trap", 64'(unimpl_trap), 64'(k == OP_EXT));
    chk("unfinished", 64'(unfinished_exc), 64'h0);
    chk("dbl", 64'(result_dbl), 64'(k == OP_STOD || (k == OP_ARITH && d)));
    @(negedge clock);
    chk("pulse", 64'(result_valid), 64'h0);
    chk("pulse exc", 64'({invalid_exc, unimpl_trap}), 64'h0);
  endtask

  // Two requests on consecutive edges, answers one cycle apart
  task automatic t_back_to_back;
    i_fp_issue_model.drive(OP_ARITH, 1'b0, 64'hFFC00003, 64'h0, 1'b0);
    i_fp_issue_model.drive(OP_EXT, 1'b0, 64'h3F800000, 64'h0, 1'b0);
    chk("b2b valid1", 64'(result_valid), 64'h1);
    chk("b2b result1", result, 64'h7FC00003);
    chk("b2b inv1", 64'(invalid_exc), 64'h0);
    chk("b2b trap1", 64'(unimpl_trap), 64'h0);
    i_fp_issue_model.release_bus();
    chk("b2b valid2", 64'(result_valid), 64'h1);
    chk("b2b result2", result, 64'h0);
    chk("b2b trap2", 64'(unimpl_trap), 64'h1);
    @(negedge clock);
    chk("b2b pulse", 64'({result_valid, unimpl_trap}), 64'h0);
  endtask

  task automatic t_classes;
    logic d;
    logic [63:0] er;
    for (int i = 0; i < 16; i++) begin
      d = (i > 8);
      er = d ? 64'h7FFFFFFFFFFFFFFF : 64'h000000007FFFFFFF;
      er = CC[i] == CLS_QNAN ? CV[i] & er : AR;
      if (CC[i] == CLS_SIGNALING_NAN) er = d ? DEFAULT_NAN_DP : DS;
      do_op(OP_ARITH, d, CV[i], 64'h0, 0, er, CC[i] == CLS_SIGNALING_NAN);
      chk("class", 64'(first_class), 64'(CC[i]));
      chk("exp", 64'(first_true_exp), 64'(CE[i]));
      chk("class2", 64'(second_class), 64'(CLS_ZERO));
    end
  endtask

  task automatic t_priority;
    do_op(OP_ARITH,0,64'hFFC00001,64'h7FC00002,0,64'h7FC00001,0);
    do_op(OP_ARITH,0,64'h7FC00001,64'h7F800001,0,DS,1);
    do_op(OP_ARITH,0,64'h0,64'hFFC00005,0,64'h7FC00005,0);
    do_op(OP_ARITH,0,64'h3F800000,64'h3F800000,1,DS,1);
    do_op(OP_ARITH,1,64'h0,64'hFFF8000000000003,0,
          64'h7FF8000000000003,0);
    do_op(OP_ARITH,1,64'hFFF0000000000001,64'h0,0,DEFAULT_NAN_DP,1);
  endtask

  task automatic t_converts;
    do_op(OP_STOI,0,64'h0,64'h7FC00000,0,{32'h0,INT_POS_SAT},1);
    do_op(OP_STOI,0,64'h0,64'hFF800001,0,{32'h0,INT_NEG_SAT},1);
    do_op(OP_DTOI,0,64'h0,64'hFFF8000000000000,0,
          {32'h0,INT_NEG_SAT},1);
    do_op(OP_DTOI,0,64'h0,64'h7FF0000000000001,0,
          {32'h0,INT_POS_SAT},1);
    do_op(OP_STOD,0,64'h0,64'hFFC00001,0,64'h7FF8000020000000,0);
    do_op(OP_STOD,0,64'h0,64'h7F800001,0,DEFAULT_NAN_DP,1);
    do_op(OP_DTOS,0,64'h0,64'h7FF8000000000000,0,DS,0);
    do_op(OP_DTOS,0,64'h0,64'hFFF0000000000001,0,DS,1);
    do_op(OP_DTOS,0,64'h0,64'h3FF0000000000000,1,DS,1);
    do_op(OP_STOI,0,64'h0,64'h3F800000,1,AR,1);
    do_op(OP_EXT,0,64'h3F800000,64'h3F800000,0,64'h0,0);
  endtask

  initial begin
    srst = 1'b1;
    t_reset();
    t_classes();
    t_priority();
    t_reset();
    t_converts();
    t_back_to_back();
    end_sim();
  end
endmodule // fp_nan_result_tb
